// >>> rtl/clock_divider_pkg.sv
// Function
// - Self clock mode runs core at the self clock rate, bus at half of it.
// - Entering self clock mode clears the PLL source select bit automatically.
// - Flash path divides oscillator by eight when prescale bit set, else passes it.
// - Flash divider divides by six-bit field plus one, range 1 to 64.
// - Serial baud divisor is thirteen bits; zero stops the baud generator.
// - Normal serial baud is bus clock over sixteen times the divisor.
// - Infrared mode gives bus clock over thirty-two times divisor upper twelve bits.
// - SPI baud is bus over (preselect plus one) times two to (rate plus one).
// - I2C baud is bus over mul times twice (2 + scl2tap + (tap-1) * spacing).
// - I2C code decodes multiplier, spacing, tap count and scl2tap with listed exceptions.
// - Timer clock is bus clock over two to the three-bit prescale field.
// - Converter clock is bus clock over twice the five-bit field plus one.
// - Periodic rate is input over (modulus plus one) times two to (9 + prescale).
// - Periodic interrupt off at zero prescale; uses self clock in self clock mode.
// - Watchdog timeout is two to (12 + 2 * field) periods; 6 and 7 give 2^23, 2^24.
// - Watchdog field zero disables the timeout.
// - Periodic divider and watchdog run from the gated oscillator clock.
// - Serial, SPI, I2C, timer and converter dividers use only the bus clock.
// - PLL select picks PLL or oscillator as system clock; bus is half of it.
package clock_divider_pkg;
  localparam int CNT_W = 25;
  localparam int DIV_N = 9;
  localparam int DIV_FLASH_PRE = 0;
  localparam int DIV_FLASH = 1;
  localparam int DIV_SERIAL = 2;
  localparam int DIV_SPI = 3;
  localparam int DIV_I2C = 4;
  localparam int DIV_TIMER = 5;
  localparam int DIV_CONVERTER = 6;
  localparam int DIV_PERIODIC = 7;
  localparam int DIV_WATCHDOG = 8;
  localparam logic [CNT_W-1:0] FLASH_PRE_DIVIDE = 25'h0000008;
  localparam int SERIAL_NORMAL_SHIFT = 4;
  localparam int SERIAL_IR_SHIFT = 5;
  localparam logic [CNT_W-1:0] I2C_BASE_ADD = 25'h0000002;
  localparam logic [CNT_W-1:0] I2C_TAP_BASE = 25'h0000005;
  localparam logic [CNT_W-1:0] I2C_TAP_CODE6 = 25'h000000c;
  localparam logic [CNT_W-1:0] I2C_TAP_CODE7 = 25'h000000f;
  localparam logic [CNT_W-1:0] I2C_SCL2TAP_CODE0 = 25'h0000004;
  localparam logic [CNT_W-1:0] I2C_SCL2TAP_CODE1 = 25'h0000004;
  localparam logic [CNT_W-1:0] I2C_SCL2TAP_CODE2 = 25'h0000006;
  localparam logic [CNT_W-1:0] I2C_SCL2TAP_SUB = 25'h0000002;
  localparam logic [4:0] PERIODIC_BASE_EXP = 5'h09;
  localparam logic [4:0] WATCHDOG_BASE_EXP = 5'h0c;
  localparam logic [4:0] WATCHDOG_EXP_CODE6 = 5'h17;
  localparam logic [4:0] WATCHDOG_EXP_CODE7 = 5'h18;
  localparam logic PLL_SELECT_RESET = 1'h0;

  typedef struct packed {
    logic flash_divide_by_eight;
    logic [5:0] flash_divide_field;
    logic infrared_enable;
    logic [12:0] serial_baud_divisor;
    logic [2:0] spi_preselect;
    logic [2:0] spi_rate_exponent;
    logic [7:0] i2c_divider_code;
    logic [2:0] timer_divide_select;
    logic [4:0] converter_divide_select;
    logic [6:0] periodic_divide_fields;
    logic [2:0] watchdog_timeout_select;
  } divide_config_type;

  typedef struct packed {
    logic flash;
    logic serial;
    logic spi;
    logic i2c;
    logic timer;
    logic converter;
    logic periodic_interrupt;
    logic watchdog_timeout;
  } rate_ticks_type;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic pulse;
  } divider_state_type;

  typedef enum logic [1:0] {
    MODE_OSC = 2'b00,
    MODE_PLL = 2'b01,
    MODE_SELF = 2'b11
  } clock_mode_type;

  typedef struct packed {
    clock_mode_type mode;
    logic pll_sel;
    logic scm_prev;
    logic bus_phase;
    logic core_tick;
    logic bus_tick;
    logic osc_tick;
  } clock_state_type;
endpackage : clock_divider_pkg

// >>> rtl/peripheral_clock_dividers.sv
`timescale 1ns/1ps
`default_nettype none
module peripheral_clock_dividers
  import clock_divider_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic osc_tick,
  input wire logic pll_tick,
  input wire logic scm_tick,
  input wire logic self_clock_mode,
  input wire logic osc_gate_enable,
  input wire logic pll_select_write,
  input wire logic pll_select_wdata,
  input wire logic watchdog_service,
  input wire divide_config_type cfg,
  output logic pll_source_select,
  output logic core_tick,
  output logic bus_tick,
  output rate_ticks_type ticks
);
  clock_state_type s_q;
  clock_state_type s_d;
  logic sys_src;
  logic osc_src;
  logic gated_osc;
  logic [DIV_N-1:0] div_tick;
  logic [DIV_N-1:0] div_enable;
  logic [DIV_N-1:0] div_restart;
  logic [DIV_N-1:0] div_pulse;
  logic [CNT_W-1:0] div_limit [DIV_N];

  function automatic logic [CNT_W-1:0] pow2_minus1(input logic [4:0] e);
    logic [CNT_W-1:0] one;
    one = 25'h0000001;
    return (one << e) - one;
  endfunction : pow2_minus1

  function automatic logic [CNT_W-1:0] widen3(input logic [2:0] v);
    return {22'h000000, v};
  endfunction : widen3

  function automatic logic [CNT_W-1:0] serial_limit(
    input logic [12:0] divisor,
    input logic infrared
  );
    logic [CNT_W-1:0] wide;
    wide = {12'h000, divisor};
    if (infrared)
    begin
      wide = {13'h0000, divisor[12:1]};
      return (wide << SERIAL_IR_SHIFT) - 25'h0000001;
    end
    return (wide << SERIAL_NORMAL_SHIFT) - 25'h0000001;
  endfunction : serial_limit

  function automatic logic serial_on(
    input logic [12:0] divisor,
    input logic infrared
  );
    if (infrared)
    begin
      return divisor[12:1] != 12'h000;
    end
    return divisor != 13'h0000;
  endfunction : serial_on

  function automatic logic [CNT_W-1:0] spi_limit(
    input logic [2:0] preselect,
    input logic [2:0] rate
  );
    logic [CNT_W-1:0] pre;
    logic [4:0] sh;
    pre = widen3(preselect) + 25'h0000001;
    sh = {2'h0, rate} + 5'h01;
    return (pre << sh) - 25'h0000001;
  endfunction : spi_limit

  function automatic logic [CNT_W-1:0] i2c_limit(input logic [7:0] code);
    logic [CNT_W-1:0] tap;
    logic [CNT_W-1:0] spacing;
    logic [CNT_W-1:0] scl2tap;
    logic [CNT_W-1:0] inner;
    logic [4:0] mul_exp;
    tap = '0;
    spacing = '0;
    scl2tap = '0;
    inner = '0;
    mul_exp = {3'h0, code[7:6]};
    spacing = 25'h0000001 << code[5:3];
    unique case (code[2:0])
      3'h6: tap = I2C_TAP_CODE6;
      3'h7: tap = I2C_TAP_CODE7;
      default: tap = I2C_TAP_BASE + widen3(code[2:0]);
    endcase
    unique case (code[5:3])
      3'h0: scl2tap = I2C_SCL2TAP_CODE0;
      3'h1: scl2tap = I2C_SCL2TAP_CODE1;
      3'h2: scl2tap = I2C_SCL2TAP_CODE2;
      default: scl2tap = spacing - I2C_SCL2TAP_SUB;
    endcase
    inner = I2C_BASE_ADD + scl2tap + (tap - 25'h0000001) * spacing;
    return ((inner << 1) << mul_exp) - 25'h0000001;
  endfunction : i2c_limit

  function automatic logic [CNT_W-1:0] timer_limit(input logic [2:0] sel);
    return pow2_minus1({2'h0, sel});
  endfunction : timer_limit

  function automatic logic [CNT_W-1:0] converter_limit(input logic [4:0] sel);
    logic [CNT_W-1:0] wide;
    wide = {20'h00000, sel};
    return (wide << 1) + 25'h0000001;
  endfunction : converter_limit

  function automatic logic [CNT_W-1:0] periodic_limit(input logic [6:0] fields);
    logic [CNT_W-1:0] modulus;
    logic [4:0] sh;
    modulus = {21'h000000, fields[3:0]} + 25'h0000001;
    sh = PERIODIC_BASE_EXP + {2'h0, fields[6:4]};
    return (modulus << sh) - 25'h0000001;
  endfunction : periodic_limit

  function automatic logic [CNT_W-1:0] watchdog_limit(input logic [2:0] sel);
    logic [4:0] e;
    e = '0;
    unique case (sel)
      3'h6: e = WATCHDOG_EXP_CODE6;
      3'h7: e = WATCHDOG_EXP_CODE7;
      default: e = WATCHDOG_BASE_EXP + {1'h0, sel, 1'h0};
    endcase
    return pow2_minus1(e);
  endfunction : watchdog_limit

  // System clock source selection
  always_comb
  begin
    unique case (s_q.mode)
      MODE_SELF: sys_src = scm_tick;
      MODE_PLL: sys_src = pll_tick;
      MODE_OSC: sys_src = osc_tick;
      default: sys_src = osc_tick;
    endcase
  end

  // Oscillator follows the self clock while in self clock mode
  assign osc_src = self_clock_mode ? scm_tick : osc_tick;
  assign gated_osc = s_q.osc_tick & osc_gate_enable;

  always_comb
  begin
    s_d = s_q;
    s_d.scm_prev = self_clock_mode;
    if (pll_select_write)
    begin
      s_d.pll_sel = pll_select_wdata;
    end
    if (self_clock_mode && !s_q.scm_prev)
    begin
      s_d.pll_sel = 1'b0;
    end
    if (self_clock_mode)
    begin
      s_d.mode = MODE_SELF;
    end
    else if (s_d.pll_sel)
    begin
      s_d.mode = MODE_PLL;
    end
    else
    begin
      s_d.mode = MODE_OSC;
    end
    s_d.core_tick = sys_src;
    s_d.bus_tick = sys_src & s_q.bus_phase;
    if (sys_src)
    begin
      s_d.bus_phase = ~s_q.bus_phase;
    end
    s_d.osc_tick = osc_src;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_q.mode <= MODE_OSC;
      s_q.pll_sel <= PLL_SELECT_RESET;
      s_q.scm_prev <= 1'b0;
      s_q.bus_phase <= 1'b0;
      s_q.core_tick <= 1'b0;
      s_q.bus_tick <= 1'b0;
      s_q.osc_tick <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Divider inputs
  always_comb
  begin
    div_tick = '0;
    div_enable = '1;
    div_restart = '0;
    div_tick[DIV_FLASH_PRE] = s_q.osc_tick;
    div_enable[DIV_FLASH_PRE] = cfg.flash_divide_by_eight;
    div_limit[DIV_FLASH_PRE] = FLASH_PRE_DIVIDE - 25'h0000001;
    if (cfg.flash_divide_by_eight)
    begin
      div_tick[DIV_FLASH] = div_pulse[DIV_FLASH_PRE];
    end
    else
    begin
      div_tick[DIV_FLASH] = s_q.osc_tick;
    end
    div_limit[DIV_FLASH] = {19'h00000, cfg.flash_divide_field};
    div_tick[DIV_SERIAL] = s_q.bus_tick;
    div_enable[DIV_SERIAL] = serial_on(cfg.serial_baud_divisor,
      cfg.infrared_enable);
    div_limit[DIV_SERIAL] = serial_limit(cfg.serial_baud_divisor,
      cfg.infrared_enable);
    div_tick[DIV_SPI] = s_q.bus_tick;
    div_limit[DIV_SPI] = spi_limit(cfg.spi_preselect, cfg.spi_rate_exponent);
    div_tick[DIV_I2C] = s_q.bus_tick;
    div_limit[DIV_I2C] = i2c_limit(cfg.i2c_divider_code);
    div_tick[DIV_TIMER] = s_q.bus_tick;
    div_limit[DIV_TIMER] = timer_limit(cfg.timer_divide_select);
    div_tick[DIV_CONVERTER] = s_q.bus_tick;
    div_limit[DIV_CONVERTER] = converter_limit(cfg.converter_divide_select);
    div_tick[DIV_PERIODIC] = gated_osc;
    div_enable[DIV_PERIODIC] = cfg.periodic_divide_fields[6:4] != 3'h0;
    div_limit[DIV_PERIODIC] = periodic_limit(cfg.periodic_divide_fields);
    div_tick[DIV_WATCHDOG] = gated_osc;
    div_enable[DIV_WATCHDOG] = cfg.watchdog_timeout_select != 3'h0;
    div_restart[DIV_WATCHDOG] = watchdog_service;
    div_limit[DIV_WATCHDOG] = watchdog_limit(cfg.watchdog_timeout_select);
  end

  genvar gi;
  generate
    for (gi = 0; gi < DIV_N; gi++)
    begin : g_div
      rate_divider u_div (
        .mclk(mclk),
        .srst(srst),
        .tick(div_tick[gi]),
        .enable(div_enable[gi]),
        .restart(div_restart[gi]),
        .limit(div_limit[gi]),
        .pulse(div_pulse[gi])
      );
    end
  endgenerate

  assign pll_source_select = s_q.pll_sel;
  assign core_tick = s_q.core_tick;
  assign bus_tick = s_q.bus_tick;
  assign ticks.flash = div_pulse[DIV_FLASH];
  assign ticks.serial = div_pulse[DIV_SERIAL];
  assign ticks.spi = div_pulse[DIV_SPI];
  assign ticks.i2c = div_pulse[DIV_I2C];
  assign ticks.timer = div_pulse[DIV_TIMER];
  assign ticks.converter = div_pulse[DIV_CONVERTER];
  assign ticks.periodic_interrupt = div_pulse[DIV_PERIODIC];
  assign ticks.watchdog_timeout = div_pulse[DIV_WATCHDOG];
endmodule : peripheral_clock_dividers
`default_nettype wire

// >>> rtl/rate_divider.sv
`timescale 1ns/1ps
`default_nettype none
module rate_divider
  import clock_divider_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic tick,
  input wire logic enable,
  input wire logic restart,
  input wire logic [CNT_W-1:0] limit,
  output logic pulse
);
  divider_state_type s_q;
  divider_state_type s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (!enable || restart)
    begin
      s_d.cnt = '0;
    end
    else if (tick)
    begin
      if (s_q.cnt >= limit)
      begin
        s_d.cnt = '0;
        s_d.pulse = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt + 25'h0000001;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pulse = s_q.pulse;
endmodule : rate_divider
`default_nettype wire

// >>> verification/peripheral_clock_dividers_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module peripheral_clock_dividers_asserts
  import clock_divider_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic osc_tick,
  input wire logic pll_tick,
  input wire logic scm_tick,
  input wire logic self_clock_mode,
  input wire divide_config_type cfg,
  input wire logic pll_source_select,
  input wire logic core_tick,
  input wire logic bus_tick,
  input wire rate_ticks_type ticks
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  property p_bus_gap;
    bus_tick |=> !bus_tick;
  endproperty
  a_bus_gap: assert property (p_bus_gap) else $error("bus tick twice");
  property p_bus_core;
    bus_tick |-> core_tick;
  endproperty
  a_bus_core: assert property (p_bus_core) else $error("bus without core");
  property p_osc_core;
    !self_clock_mode && !$past(self_clock_mode) && !pll_source_select
      && !$past(pll_source_select) && osc_tick |=> core_tick;
  endproperty
  a_osc_core: assert property (p_osc_core) else $error("osc core missed");
  property p_pll_core;
    !self_clock_mode && !$past(self_clock_mode) && pll_source_select
      && $past(pll_source_select) && pll_tick |=> core_tick;
  endproperty
  a_pll_core: assert property (p_pll_core) else $error("pll core missed");
  property p_scm_core;
    self_clock_mode && $past(self_clock_mode) && scm_tick |=> core_tick;
  endproperty
  a_scm_core: assert property (p_scm_core) else $error("self core missed");
  property p_scm_clr;
    $rose(self_clock_mode) |=> !pll_source_select;
  endproperty
  a_scm_clr: assert property (p_scm_clr) else $error("pll select kept");
  property p_bus_only;
    (ticks.serial || ticks.spi || ticks.i2c || ticks.timer || ticks.converter)
      |-> $past(bus_tick);
  endproperty
  a_bus_only: assert property (p_bus_only) else $error("pulse without bus");
  property p_timer0;
    cfg.timer_divide_select == 3'h0 && $stable(cfg.timer_divide_select) && bus_tick
      |=> ticks.timer;
  endproperty
  a_timer0: assert property (p_timer0) else $error("timer pulse missed");
  property p_serial_off;
    cfg.serial_baud_divisor == 13'h0 && $past(cfg.serial_baud_divisor) == 13'h0
      |-> !ticks.serial;
  endproperty
  a_serial_off: assert property (p_serial_off) else $error("serial not off");
endmodule : peripheral_clock_dividers_asserts
`default_nettype wire

// >>> verification/peripheral_clock_dividers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module peripheral_clock_dividers_tb
  import clock_divider_pkg::*;
;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic osc_tick = 1'b1;
  logic pll_tick = 1'b0;
  logic scm_tick = 1'b0;
  logic self_clock_mode = 1'b0;
  logic osc_gate_enable = 1'b1;
  logic pll_select_write = 1'b0;
  logic pll_select_wdata = 1'b0;
  logic watchdog_service = 1'b0;
  divide_config_type cfg = '0;
  logic pll_source_select;
  logic core_tick;
  logic bus_tick;
  rate_ticks_type ticks;
  int mismatches = 0;
  int check_count = 0;
  int bp = 2;
  int op = 1;
  int scm_phase = 0;
  logic [31:0] r = 32'hf74d06db;
  always #2.5 mclk = ~mclk;
  always @(negedge mclk)
  begin
    pll_tick <= ~pll_tick;
    scm_phase <= (scm_phase == 2) ? 0 : scm_phase + 1;
    scm_tick <= (scm_phase == 2);
  end
  peripheral_clock_dividers DUT (.mclk(mclk), .srst(srst), .osc_tick(osc_tick),
    .pll_tick(pll_tick), .scm_tick(scm_tick), .self_clock_mode(self_clock_mode),
    .osc_gate_enable(osc_gate_enable), .pll_select_write(pll_select_write),
    .pll_select_wdata(pll_select_wdata), .watchdog_service(watchdog_service),
    .cfg(cfg), .pll_source_select(pll_source_select), .core_tick(core_tick),
    .bus_tick(bus_tick), .ticks(ticks));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected pulse period in mclk cycles
  function automatic int ep(input int i);
    logic [7:0] k;
    int t;
    int s;
    k = cfg.i2c_divider_code;
    t = (k[2:0] == 3'h6) ? 12 : (k[2:0] == 3'h7) ? 15 : 5 + k[2:0];
    s = (k[5:3] < 3'h2) ? 4 : (k[5:3] == 3'h2) ? 6 : (1 << k[5:3]) - 2;
    case (i)
      0: return (cfg.flash_divide_by_eight ? 8 : 1) * (cfg.flash_divide_field + 1) * op;
      1: return cfg.infrared_enable ? 32 * cfg.serial_baud_divisor[12:1] * bp
        : 16 * cfg.serial_baud_divisor * bp;
      2: return (cfg.spi_preselect + 1) * (2 << cfg.spi_rate_exponent) * bp;
      3: return (1 << k[7:6]) * 2 * (2 + s + (t - 1) * (1 << k[5:3])) * bp;
      4: return (1 << cfg.timer_divide_select) * bp;
      5: return 2 * (cfg.converter_divide_select + 1) * bp;
      6: return (cfg.periodic_divide_fields[6:4] == 3'h0) ? 0
        : (cfg.periodic_divide_fields[3:0] + 1)
        * (1 << (9 + cfg.periodic_divide_fields[6:4])) * op;
      default: return ((cfg.watchdog_timeout_select == 3'h0) ? 0
        : (cfg.watchdog_timeout_select == 3'h6) ? (1 << 23)
        : (cfg.watchdog_timeout_select == 3'h7) ? (1 << 24)
        : (1 << (12 + 2 * cfg.watchdog_timeout_select))) * op;
    endcase
  endfunction : ep
  task automatic results();
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask : check
  // Cycles between two pulses of one tick field, 0 if none
  task automatic meas(input int i, input int e);
    int n;
    int p;
    int got;
    p = 0;
    got = 0;
    for (n = 0; n < 2 * e + 2100 && p < 2; n++)
    begin
      @(negedge mclk);
      if (p == 1)
        got++;
      if (ticks[7-i] === 1'b1)
        p++;
    end
    if (p < 2)
      got = 0;
    check($sformatf("period%0d", i), got, e);
    if (p < 2 && e != 0)
      results();
  endtask : meas
  initial
  begin
    logic [31:0] q;
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    check("ticks", ticks, 32'h0);
    check("pll_sel", pll_source_select, 32'h0);
    for (int it = 0; it < 4; it++)
    begin
      r = lfsr(r);
      q = (it == 0) ? 32'h0 : (it == 1) ? 32'hffffffff : r;
      cfg.flash_divide_by_eight = q[0];
      cfg.flash_divide_field = q[6:1];
      cfg.infrared_enable = q[7];
      cfg.serial_baud_divisor = {9'h0, q[11:8]};
      cfg.spi_preselect = q[14:12];
      cfg.spi_rate_exponent = {1'b0, q[16:15]};
      cfg.i2c_divider_code = {1'b0, q[17], 1'b0, q[19:18], q[22:20]};
      cfg.timer_divide_select = q[25:23];
      cfg.converter_divide_select = q[30:26];
      cfg.periodic_divide_fields = {2'h0, q[31], 3'h0, q[1]};
      for (int i = 0; i < 7; i++)
        meas(i, ep(i));
    end
    pll_select_write = 1'b1;
    pll_select_wdata = 1'b1;
    @(negedge mclk);
    pll_select_write = 1'b0;
    @(negedge mclk);
    check("pll_sel", pll_source_select, 32'h1);
    bp = 4;
    meas(4, ep(4));
    self_clock_mode = 1'b1;
    pll_select_write = 1'b1;
    @(negedge mclk);
    pll_select_write = 1'b0;
    @(negedge mclk);
    check("pll_sel", pll_source_select, 32'h0);
    op = 3;
    bp = 6;
    cfg.flash_divide_by_eight = 1'b1;
    cfg.flash_divide_field = 6'h2f;
    meas(0, ep(0));
    meas(4, ep(4));
    self_clock_mode = 1'b0;
    bp = 2;
    op = 1;
    cfg.converter_divide_select = 5'h1f;
    meas(5, ep(5));
    osc_gate_enable = 1'b0;
    cfg.periodic_divide_fields = 7'h10;
    meas(6, 0);
    osc_gate_enable = 1'b1;
    meas(6, ep(6));
    cfg.watchdog_timeout_select = 3'h0;
    meas(7, ep(7));
    cfg.watchdog_timeout_select = 3'h1;
    meas(7, ep(7));
    results();
  end
endmodule : peripheral_clock_dividers_tb
bind peripheral_clock_dividers peripheral_clock_dividers_asserts chk (.mclk(mclk),
  .srst(srst), .osc_tick(osc_tick), .pll_tick(pll_tick), .scm_tick(scm_tick),
  .self_clock_mode(self_clock_mode), .cfg(cfg), .pll_source_select(pll_source_select),
  .core_tick(core_tick), .bus_tick(bus_tick), .ticks(ticks));
`default_nettype wire
